// ### rtl/network_status_indicators.sv
// network status lamps, thin-cable enable and their AHB-Lite registers
// Overview of operation
// - seven reversed link pulses light polarity lamp
// - three reversed packets also light polarity lamp
// - any transmission lights send lamp about 50 ms
// - valid receive data pulls receive lamp low
// - collision pulls collision lamp low about 50 ms
// - link lamp off in AUI, or with test on and failing link
// - link lamp on in twisted pair if test off or passing
// - thin media selection drives thin-cable output high
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "ind_defs.svh"

module network_status_indicators #(
	parameter logic [`HOLD_W-1:0] LAMP_HOLD = `HOLD_W'(`LAMP_HOLD_CYCLES)
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// bus slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// events from mac, manchester_codec and twisted_pair_port receiver
	input  wire logic                send_event,
	input  wire logic                receive_event,
	input  wire logic                collision_event,
	input  wire logic                link_pulse,
	input  wire logic                link_pulse_reversed,
	input  wire logic                packet_done,
	input  wire logic                packet_reversed,
	input  wire logic                link_pass,
	// lamps and converter enable
	output logic                     polarity_lamp_n,
	output logic                     send_lamp_n,
	output logic                     receive_lamp_n,
	output logic                     receive_lamp_n_oe,
	output logic                     collision_lamp_n,
	output logic                     collision_lamp_n_oe,
	output logic                     link_ok_lamp_n,
	output logic                     link_ok_lamp_n_oe,
	output logic                     thin_cable,
	output ind_pkg::media_t          media_select
);
	import ind_pkg::*;

	// bus state
	logic                     wr_pend_reg;
	logic                     wr_pend_next;
	logic [`ADDR_W-1:0]       wr_addr_reg;
	logic [`ADDR_W-1:0]       wr_addr_next;
	logic [31:0]              hrdata_next;
	logic                     accept;
	logic [31:0]              status_word;
	// configuration state
	media_t                   media_reg;
	media_t                   media_next;
	logic                     ltest_reg;
	logic                     ltest_next;
	// polarity state
	logic [`PULSE_CNT_W-1:0]  pulse_cnt_reg;
	logic [`PULSE_CNT_W-1:0]  pulse_cnt_next;
	logic [`PACKET_CNT_W-1:0] packet_cnt_reg;
	logic [`PACKET_CNT_W-1:0] packet_cnt_next;
	logic                     pol_rev_reg;
	logic                     pol_rev_next;
	// lamp state
	logic                     link_on_next;
	logic                     thin_next;
	logic                     send_on;
	logic                     recv_on;
	logic                     coll_on;
	logic                     tp_sel;

	assign tp_sel = (media_reg == MEDIA_TP);

	// zero-wait slave: a transfer is taken whenever the bus is ready
	assign accept = hsel && hready && htrans[`HTRANS_ACT_BIT];

	// status word assembled from live block state
	always_comb begin
		status_word                           = `DATA_ZERO;
		status_word[`ST_SEND]                 = send_on;
		status_word[`ST_RECV]                 = recv_on;
		status_word[`ST_COLL]                 = coll_on;
		status_word[`ST_LINK_LAMP]            = link_ok_lamp_n_oe;
		status_word[`ST_POL_REV]              = pol_rev_reg;
		status_word[`ST_LINK_PASS]            = link_pass;
		status_word[`ST_THIN]                 = thin_cable;
		status_word[`ST_PCNT_HI:`ST_PCNT_LO]  = pulse_cnt_reg;
		status_word[`ST_KCNT_HI:`ST_KCNT_LO]  = packet_cnt_reg;
	end

	// bus and config next state; write data lands in the data phase
	always_comb begin
		wr_pend_next = accept && hwrite;
		wr_addr_next = accept ? haddr[`ADDR_W-1:0] : wr_addr_reg;
		media_next   = media_reg;
		ltest_next   = ltest_reg;
		hrdata_next  = hrdata;
		if (wr_pend_reg && (wr_addr_reg == `REG_CONFIG)) begin
			media_next = media_t'(hwdata[`CFG_MEDIA_HI:`CFG_MEDIA_LO]);
			ltest_next = hwdata[`CFG_LTEST];
		end
		// reads sample the post-write config so back-to-back access sees it
		if (accept && !hwrite) begin
			case (haddr[`ADDR_W-1:0])
				`REG_CONFIG: begin
					hrdata_next                             = `DATA_ZERO;
					hrdata_next[`CFG_MEDIA_HI:`CFG_MEDIA_LO] = media_next;
					hrdata_next[`CFG_LTEST]                 = ltest_next;
				end
				`REG_STATUS: begin
					hrdata_next = status_word;
				end
				default: begin
					hrdata_next = `DATA_ZERO; // unmapped reads as zero
				end
			endcase
		end
	end

	// bus and config registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_reg  <= 1'b0;
			wr_addr_reg  <= `REG_CONFIG;
			hrdata       <= `DATA_ZERO;
			hreadyout    <= 1'b1;
			hresp        <= `HRESP_OKAY;
			media_reg    <= MEDIA_THICK;
			media_select <= MEDIA_THICK;
			ltest_reg    <= `CFG_LTEST_RESET;
		end else begin
			wr_pend_reg  <= wr_pend_next;
			wr_addr_reg  <= wr_addr_next;
			hrdata       <= hrdata_next;
			hreadyout    <= 1'b1;
			hresp        <= `HRESP_OKAY;
			media_reg    <= media_next;
			media_select <= media_next;
			ltest_reg    <= ltest_next;
		end
	end

	// polarity runs; a correct-polarity event breaks the run and clears
	// the lamp, unless the other run counter holds or reaches its full run that cycle
	always_comb begin
		pulse_cnt_next  = pulse_cnt_reg;
		packet_cnt_next = packet_cnt_reg;
		pol_rev_next    = pol_rev_reg;
		if (!tp_sel) begin
			pulse_cnt_next  = '0; // polarity only has meaning on twisted pair
			packet_cnt_next = '0;
			pol_rev_next    = 1'b0;
		end else begin
			if (link_pulse && !link_pulse_reversed) begin
				pulse_cnt_next = '0;
				pol_rev_next   = 1'b0;
			end else if (link_pulse && (pulse_cnt_reg != `POL_PULSE_RUN)) begin
				pulse_cnt_next = pulse_cnt_reg + `POL_PULSE_ONE;
			end
			if (packet_done && !packet_reversed) begin
				packet_cnt_next = '0;
				pol_rev_next    = 1'b0;
			end else if (packet_done && (packet_cnt_reg != `POL_PACKET_RUN)) begin
				packet_cnt_next = packet_cnt_reg + `POL_PACKET_ONE;
			end
			if (pulse_cnt_next == `POL_PULSE_RUN) begin
				pol_rev_next = 1'b1;
			end
			if (packet_cnt_next == `POL_PACKET_RUN) begin
				pol_rev_next = 1'b1;
			end
		end
	end

	// polarity registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_cnt_reg   <= '0;
			packet_cnt_reg  <= '0;
			pol_rev_reg     <= 1'b0;
			polarity_lamp_n <= 1'b1;
		end else begin
			pulse_cnt_reg   <= pulse_cnt_next;
			packet_cnt_reg  <= packet_cnt_next;
			pol_rev_reg     <= pol_rev_next;
			polarity_lamp_n <= !pol_rev_next;
		end
	end

	// link lamp and thin-cable enable follow config one cycle later
	always_comb begin
		link_on_next = tp_sel && (!ltest_reg || link_pass);
		thin_next    = (media_reg == MEDIA_THIN);
	end

	// open-drain pins only ever drive low, so their level flops stay zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			link_ok_lamp_n_oe <= 1'b0;
			link_ok_lamp_n    <= 1'b0;
			receive_lamp_n    <= 1'b0;
			collision_lamp_n  <= 1'b0;
			thin_cable        <= 1'b0;
		end else begin
			link_ok_lamp_n_oe <= link_on_next;
			link_ok_lamp_n    <= 1'b0;
			receive_lamp_n    <= 1'b0;
			collision_lamp_n  <= 1'b0;
			thin_cable        <= thin_next;
		end
	end

	// send lamp: push-pull, lit on any transmission in every media mode
	lamp_stretch #(
		.HOLD    (LAMP_HOLD)
	) u_send (
		.clk     (clk),
		.sys_rst (sys_rst),
		.trigger (send_event),
		.lamp_on (send_on),
		.lamp_n  (send_lamp_n)
	);

	// receive lamp: open drain, enable is the pull-low
	lamp_stretch #(
		.HOLD    (LAMP_HOLD)
	) u_recv (
		.clk     (clk),
		.sys_rst (sys_rst),
		.trigger (receive_event),
		.lamp_on (receive_lamp_n_oe),
		.lamp_n  ()
	);

	// collision lamp: open drain, enable is the pull-low
	lamp_stretch #(
		.HOLD    (LAMP_HOLD)
	) u_coll (
		.clk     (clk),
		.sys_rst (sys_rst),
		.trigger (collision_event),
		.lamp_on (collision_lamp_n_oe),
		.lamp_n  ()
	);

	assign recv_on = receive_lamp_n_oe;
	assign coll_on = collision_lamp_n_oe;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_pulse_run_lamp: assert property (
		tp_sel && link_pulse && link_pulse_reversed && (pulse_cnt_reg == `POL_PULSE_PRE)
		|=> !polarity_lamp_n && (pulse_cnt_reg == `POL_PULSE_RUN))
		else $error("seventh reversed pulse did not light polarity lamp");

	chk_packet_run_lamp: assert property (
		tp_sel && packet_done && packet_reversed && (packet_cnt_reg == `POL_PACKET_PRE)
		|=> !polarity_lamp_n)
		else $error("third reversed packet did not light polarity lamp");

	chk_pol_no_early: assert property (
		$fell(polarity_lamp_n) |-> ($past(pulse_cnt_next) == `POL_PULSE_RUN)
		|| ($past(packet_cnt_next) == `POL_PACKET_RUN))
		else $error("polarity lamp lit before a full run");

	chk_send_lamp_hold: assert property (
		send_event |=> !send_lamp_n [*4])
		else $error("send lamp not held low after transmit");

	chk_recv_lamp_pull: assert property (
		receive_event |=> receive_lamp_n_oe && !receive_lamp_n ##1 receive_lamp_n_oe)
		else $error("receive lamp not pulled low after valid data");

	chk_coll_lamp_pull: assert property (
		collision_event |=> collision_lamp_n_oe [*3])
		else $error("collision lamp not pulled low after collision");

	chk_link_lamp_off: assert property (
		(!tp_sel || (ltest_reg && !link_pass)) |=> !link_ok_lamp_n_oe)
		else $error("link lamp lit in aui mode or with failing link");

	chk_link_lamp_on: assert property (
		tp_sel && (!ltest_reg || link_pass) |=> link_ok_lamp_n_oe && !link_ok_lamp_n)
		else $error("link lamp dark with test off or link passing");

	chk_thin_enable: assert property (
		wr_pend_reg && (wr_addr_reg == `REG_CONFIG)
		&& (hwdata[`CFG_MEDIA_HI:`CFG_MEDIA_LO] == MEDIA_THIN) |=> ##1 thin_cable)
		else $error("thin-cable output not raised for thin media");

	chk_bus_okay: assert property (
		hreadyout && (hresp == `HRESP_OKAY))
		else $error("slave stalled or answered with error");
endmodule // network_status_indicators

// ### rtl/ind_defs.svh
// shared constants for the network status indicator block
`ifndef IND_DEFS_SVH
`define IND_DEFS_SVH

// timing base and lamp hold interval
`define CLK_MHZ          100
`define LAMP_HOLD_MS     50
`define LAMP_HOLD_CYCLES (`LAMP_HOLD_MS * `CLK_MHZ * 1000)
`define HOLD_W           23
`define HOLD_ONE         23'h000001
`define HOLD_ZERO        23'h000000

// polarity run lengths
`define PULSE_CNT_W      3
`define PACKET_CNT_W     2
`define POL_PULSE_RUN    3'h7
`define POL_PULSE_PRE    3'h6
`define POL_PULSE_ONE    3'h1
`define POL_PACKET_RUN   2'h3
`define POL_PACKET_PRE   2'h2
`define POL_PACKET_ONE   2'h1

// register bus
`define ADDR_W           8
`define REG_CONFIG       8'h00
`define REG_STATUS       8'h04
`define HTRANS_ACT_BIT   1
`define HRESP_OKAY       1'b0
`define DATA_ZERO        32'h00000000

// config fields and reset values
`define CFG_MEDIA_HI     1
`define CFG_MEDIA_LO     0
`define CFG_LTEST        2
`define CFG_LTEST_RESET  1'b1

// status fields
`define ST_SEND          0
`define ST_RECV          1
`define ST_COLL          2
`define ST_LINK_LAMP     3
`define ST_POL_REV       4
`define ST_LINK_PASS     5
`define ST_THIN          6
`define ST_PCNT_HI       10
`define ST_PCNT_LO       8
`define ST_KCNT_HI       13
`define ST_KCNT_LO       12

`endif

// ### rtl/ind_pkg.sv
// types for the network status indicator block
package ind_pkg;
	// media selection carried by the two media-select bits
	typedef enum logic [1:0] {
		MEDIA_THICK = 2'h0,
		MEDIA_THIN  = 2'h1,
		MEDIA_TP    = 2'h2,
		MEDIA_SPARE = 2'h3
	} media_t;
endpackage

// ### rtl/lamp_stretch.sv
// retriggerable lamp stretcher holding a lamp on for a fixed count
`timescale 1ns/100ps
`include "ind_defs.svh"

module lamp_stretch #(
	parameter logic [`HOLD_W-1:0] HOLD = `HOLD_W'(`LAMP_HOLD_CYCLES)
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic trigger,
	output logic      lamp_on,
	output logic      lamp_n
);
	logic [`HOLD_W-1:0] cnt_reg;
	logic [`HOLD_W-1:0] cnt_next;
	logic               on_reg;
	logic               on_next;

	// a new event reloads the full count, so bursts keep the lamp lit
	always_comb begin
		cnt_next = cnt_reg;
		if (trigger) begin
			cnt_next = HOLD;
		end else if (cnt_reg != `HOLD_ZERO) begin
			cnt_next = cnt_reg - `HOLD_ONE;
		end
		on_next = trigger || (cnt_reg > `HOLD_ONE);
	end

	// counter and both lamp polarities registered
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= `HOLD_ZERO;
			on_reg  <= 1'b0;
			lamp_n  <= 1'b1;
		end else begin
			cnt_reg <= cnt_next;
			on_reg  <= on_next;
			lamp_n  <= !on_next;
		end
	end

	assign lamp_on = on_reg;

	chk_stretch_reload: assert property (@(posedge clk) disable iff (sys_rst)
		trigger |=> (cnt_reg == HOLD) && lamp_on && !lamp_n)
		else $error("stretch count not reloaded by event");

	// a fresh event just after expiry may legally relight the lamp, so both quiet cycles are required
	chk_stretch_expire: assert property (@(posedge clk) disable iff (sys_rst)
		(cnt_reg == `HOLD_ONE) && !trigger ##1 !trigger |-> !lamp_on ##1 !lamp_on)
		else $error("lamp still lit after hold ran out");
endmodule // lamp_stretch

// ### tb/led_board.sv
// indicator board model: lamps with pull-ups and the thin-cable converter
`timescale 1ns/100ps
module led_board (
	input  wire logic receive_lamp_n,
	input  wire logic receive_lamp_n_oe,
	input  wire logic collision_lamp_n,
	input  wire logic collision_lamp_n_oe,
	input  wire logic link_ok_lamp_n,
	input  wire logic link_ok_lamp_n_oe,
	input  wire logic thin_cable,
	output logic      rx_pin,
	output logic      col_pin,
	output logic      link_pin,
	output logic      dcdc_on
);
	// released open-drain pins float up through the lamp pull-ups
	assign rx_pin   = receive_lamp_n_oe ? receive_lamp_n : 1'b1;
	assign col_pin  = collision_lamp_n_oe ? collision_lamp_n : 1'b1;
	assign link_pin = link_ok_lamp_n_oe ? link_ok_lamp_n : 1'b1;
	// the converter simply follows its enable
	assign dcdc_on  = thin_cable;
endmodule // led_board

// ### tb/testbench.sv
// self-checking bench for the network status indicator block
`timescale 1ns/100ps
`include "ind_defs.svh"
module testbench;
	import ind_pkg::*;
	localparam int HOLD = 20;
	logic        clk, sys_rst, hsel, hwrite, hready, link_pass;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  ev;
	logic        hreadyout, hresp, polarity_lamp_n, send_lamp_n, thin_cable;
	logic        receive_lamp_n, receive_lamp_n_oe, collision_lamp_n, collision_lamp_n_oe;
	logic        link_ok_lamp_n, link_ok_lamp_n_oe, rx_pin, col_pin, link_pin, dcdc_on;
	media_t      media_select;
	int          bad_count, compares, i;
	logic [2:0]  lamps;
	// rows: media[5:4], link test[3], link_pass[2], link pin[1], thin[0]
	logic [5:0]  rows [6] = '{6'h0e, 6'h17, 6'h32, 6'h2a, 6'h2c, 6'h20};

	// the single slave answers the bus itself
	assign hready = hreadyout;
	assign lamps  = {col_pin, rx_pin, send_lamp_n};

	network_status_indicators #(.LAMP_HOLD(`HOLD_W'(HOLD))) dut_u (
		.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .send_event(ev[0]), .receive_event(ev[1]),
		.collision_event(ev[2]), .link_pulse(ev[3]), .link_pulse_reversed(ev[4]),
		.packet_done(ev[5]), .packet_reversed(ev[6]), .link_pass, .polarity_lamp_n,
		.send_lamp_n, .receive_lamp_n, .receive_lamp_n_oe, .collision_lamp_n,
		.collision_lamp_n_oe, .link_ok_lamp_n, .link_ok_lamp_n_oe, .thin_cable, .media_select);

	led_board board_u (
		.receive_lamp_n, .receive_lamp_n_oe, .collision_lamp_n, .collision_lamp_n_oe,
		.link_ok_lamp_n, .link_ok_lamp_n_oe, .thin_cable, .rx_pin, .col_pin, .link_pin, .dcdc_on);

	task end_sim;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// bounded wait for hready at a rising edge; a hang ends the run
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			bad_count++;
			end_sim();
		end
	endtask

	// one single-word transfer; read data lands in rd
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	// one-cycle event pulse on the chosen inputs
	task fire(input logic [6:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 7'h00;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// watchdog against a hung sequence
	initial begin
		#1000000;
		bad_count++;
		end_sim();
	end

	initial begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		ev = 7'h00;
		link_pass = 1'b0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		tick(1);
		check(32'({polarity_lamp_n, send_lamp_n, lamps[2:1], link_pin, dcdc_on, hreadyout, hresp}), 32'hfa);
		bus(1'b0, `REG_CONFIG, 32'h0);
		check(rd, 32'h00000004);
		bus(1'b0, 32'h00000010, 32'h0);
		check(rd, 32'h00000000);
		$display("test reset done");
		// media, link test and link state against link lamp and converter
		for (i = 0; i < 6; i++) begin
			@(posedge clk) link_pass <= rows[i][2];
			bus(1'b1, `REG_CONFIG, {29'h0, rows[i][3], rows[i][5:4]});
			bus(1'b0, `REG_CONFIG, 32'h0);
			check(rd, {29'h0, rows[i][3], rows[i][5:4]});
			tick(2);
			check(32'(link_pin), 32'(rows[i][1]));
			check(32'(dcdc_on), 32'(rows[i][0]));
			check(32'(media_select), 32'(rows[i][5:4]));
			bus(1'b0, `REG_STATUS, 32'h0);
			check(32'(rd[`ST_THIN]), 32'(rows[i][0]));
			$display("test media row %0d done", i);
		end
		// each lamp holds about the stretch interval, then goes dark
		for (i = 0; i < 3; i++) begin
			fire(7'h01 << i);
			tick(HOLD - 3);
			check(32'(lamps[i]), 32'h0);
			tick(6);
			check(32'(lamps[i]), 32'h1);
		end
		$display("test lamps done");
		// a second event before expiry restarts the interval
		fire(7'h01);
		tick(10);
		fire(7'h01);
		tick(HOLD - 3);
		check(32'(send_lamp_n), 32'h0);
		tick(6);
		check(32'(send_lamp_n), 32'h1);
		$display("test retrigger done");
		// reversed runs in twisted-pair media: one short of the run stays dark
		repeat (6) fire(7'h18);
		tick(2);
		check(32'(polarity_lamp_n), 32'h1);
		fire(7'h18);
		tick(2);
		check(32'(polarity_lamp_n), 32'h0);
		fire(7'h08);
		tick(2);
		check(32'(polarity_lamp_n), 32'h1);
		repeat (2) fire(7'h60);
		tick(2);
		check(32'(polarity_lamp_n), 32'h1);
		fire(7'h60);
		tick(2);
		check(32'(polarity_lamp_n), 32'h0);
		$display("test polarity done");
		// reset in mid-run drops a lit lamp and the config
		fire(7'h01);
		@(posedge clk) sys_rst <= 1'b1;
		tick(2);
		check(32'({send_lamp_n, polarity_lamp_n, link_pin}), 32'h7);
		@(posedge clk) sys_rst <= 1'b0;
		tick(1);
		bus(1'b0, `REG_CONFIG, 32'h0);
		check(rd, 32'h00000004);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule // testbench
